/* File: core/eps_pkg.sv */
package eps_pkg;
  localparam int EPS_ADDR_W = 8;
  localparam int EPS_DATA_W = 32;
  localparam int EPS_STRM_W = 8;
  localparam logic [EPS_ADDR_W-1:0] EPS_OFF_STATUS = 8'h00;
  localparam logic [EPS_ADDR_W-1:0] EPS_OFF_MODE = 8'h04;
  localparam logic [EPS_ADDR_W-1:0] EPS_OFF_MASK = 8'h08;
  localparam int EPS_OM_LSB = 17;
  localparam int EPS_DONE_BIT = 16;
  localparam int EPS_RSV_LSB = 8;
  localparam int EPS_BOOT_BIT = 7;
  localparam int EPS_TXB_BIT = 6;
  localparam int EPS_RXB_BIT = 5;
  localparam int EPS_FAULT_BIT = 4;
  localparam int EPS_RDU_BIT = 3;
  localparam int EPS_RFD_BIT = 2;
  localparam int EPS_SUM_BIT = 0;
  localparam logic [7:0] EPS_RSV_VAL = 8'hFF;
  localparam logic [1:0] EPS_MODE_NORMAL = 2'h0;
  localparam logic [1:0] EPS_MODE_INT_LOOP = 2'h1;
  localparam logic [1:0] EPS_MODE_EXT_LOOP = 2'h2;
  localparam logic [1:0] EPS_MODE_DIAG = 2'h3;
  localparam logic [1:0] EPS_MODE_RESET = 2'h0;
  localparam logic [5:0] EPS_MASK_RESET = 6'h3F;
  localparam logic [1:0] EPS_PS_STOPPED = 2'h0;
  localparam logic [1:0] EPS_PS_RUNNING = 2'h1;
  localparam logic [1:0] EPS_PS_SUSPENDED = 2'h2;
  localparam int EPS_SYNC_STAGES = 2;
  typedef enum logic [1:0] {EPS_STOPPED, EPS_RUNNING, EPS_SUSPENDED} eps_proc_e;
endpackage : eps_pkg

/* File: core/eps_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module eps_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  import eps_pkg::*;
  // stage one feeds only stage two, so metastability never reaches logic
  logic [WIDTH-1:0] stage [EPS_SYNC_STAGES];

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < EPS_SYNC_STAGES; i++) begin
        stage[i] <= RESET_VAL;
      end
    end else begin
      stage[0] <= i_async;
      for (int i = 1; i < EPS_SYNC_STAGES; i++) begin
        stage[i] <= stage[i-1];
      end
    end
  end

  assign o_sync = stage[EPS_SYNC_STAGES-1];
endmodule : eps_sync
`default_nettype wire

/* File: core/eps_port_status.sv */
`timescale 1ns/1ps
`default_nettype none
module eps_port_status (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic i_hready,
  input wire logic [eps_pkg::EPS_DATA_W-1:0] i_hwdata,
  output logic [eps_pkg::EPS_DATA_W-1:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic o_irq,
  input wire logic i_vacc_start,
  input wire logic i_vacc_done,
  input wire logic i_boot_msg_det,
  input wire logic i_tx_wdog_expire,
  input wire logic i_rx_wdog_expire,
  input wire logic i_bus_master,
  input wire logic i_ext_fault_in_n,
  input wire logic i_host_wr_parity_err,
  input wire logic i_mem_rd_parity_err,
  input wire logic i_rx_desc_host_owned,
  input wire logic i_rx_poll_demand,
  input wire logic i_rx_frame_recognized,
  input wire logic i_rx_frame_done,
  input wire logic i_tx_start,
  input wire logic i_tx_stop,
  input wire logic i_rx_start,
  input wire logic i_rx_stop,
  input wire logic [eps_pkg::EPS_STRM_W-1:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic [eps_pkg::EPS_STRM_W-1:0] o_med_tx_data,
  output logic o_med_tx_valid,
  output logic [eps_pkg::EPS_STRM_W-1:0] o_loop_rx_data,
  output logic o_loop_rx_valid,
  output logic o_addr_filter_en,
  output logic o_boot_ind,
  output logic o_tx_abort,
  output logic o_tx_desc_err,
  output logic o_rx_abort,
  output logic o_rx_desc_last_err,
  output logic [1:0] o_tx_state,
  output logic [1:0] o_rx_state
);
  import eps_pkg::*;

  function automatic logic [1:0] state_code(input eps_proc_e s);
    unique case (s)
      EPS_STOPPED: state_code = EPS_PS_STOPPED;
      EPS_RUNNING: state_code = EPS_PS_RUNNING;
      EPS_SUSPENDED: state_code = EPS_PS_SUSPENDED;
      default: state_code = EPS_PS_STOPPED;
    endcase
  endfunction : state_code

  logic [1:0] operating_mode;
  logic access_done;
  logic remote_start_msg_flag;
  logic tx_babble_flag;
  logic rx_babble_flag;
  logic bus_fault_flag;
  logic rx_desc_unavail_flag;
  logic rx_frame_done_flag;
  logic summary_flag;
  logic [5:0] irq_mask;
  eps_proc_e tx_state;
  eps_proc_e rx_state;
  logic ext_fault_sync_n;
  logic ph_wr;
  logic [EPS_ADDR_W-1:0] ph_addr;
  logic addr_ok;
  logic wr_status;
  logic wr_mode;
  logic wr_mask;
  logic [EPS_DATA_W-1:0] status_word;
  logic [EPS_DATA_W-1:0] next_rdata;
  logic fault_evt;
  logic fault_new;
  logic rdu_set;
  logic rfd_set;

  eps_sync #(
    .WIDTH(1),
    .RESET_VAL(1'b1)
  ) u_fault_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_async(i_ext_fault_in_n),
    .o_sync(ext_fault_sync_n)
  );

  // bus: zero wait states, always OKAY
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign addr_ok = i_hsel && i_htrans[1] && i_hready;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ph_wr <= 1'b0;
      ph_addr <= '0;
    end else begin
      ph_wr <= addr_ok && i_hwrite;
      ph_addr <= i_haddr[EPS_ADDR_W-1:0];
    end
  end

  assign wr_status = ph_wr && (ph_addr == EPS_OFF_STATUS);
  assign wr_mode = ph_wr && (ph_addr == EPS_OFF_MODE);
  assign wr_mask = ph_wr && (ph_addr == EPS_OFF_MASK);

  assign summary_flag = tx_babble_flag | rx_babble_flag | bus_fault_flag |
                        rx_desc_unavail_flag | rx_frame_done_flag;

  always_comb begin
    status_word = '0;
    status_word[EPS_OM_LSB+1:EPS_OM_LSB] = operating_mode;
    status_word[EPS_DONE_BIT] = access_done;
    status_word[EPS_RSV_LSB+7:EPS_RSV_LSB] = EPS_RSV_VAL;
    status_word[EPS_BOOT_BIT] = remote_start_msg_flag;
    status_word[EPS_TXB_BIT] = tx_babble_flag;
    status_word[EPS_RXB_BIT] = rx_babble_flag;
    status_word[EPS_FAULT_BIT] = bus_fault_flag;
    status_word[EPS_RDU_BIT] = rx_desc_unavail_flag;
    status_word[EPS_RFD_BIT] = rx_frame_done_flag;
    status_word[EPS_SUM_BIT] = summary_flag;
  end

  always_comb begin
    next_rdata = '0;
    if (i_haddr[EPS_ADDR_W-1:0] == EPS_OFF_STATUS) begin
      next_rdata = status_word;
    end else if (i_haddr[EPS_ADDR_W-1:0] == EPS_OFF_MODE) begin
      next_rdata[1:0] = operating_mode;
    end else if (i_haddr[EPS_ADDR_W-1:0] == EPS_OFF_MASK) begin
      next_rdata[EPS_TXB_BIT:1] = irq_mask;
    end
  end

  // read data is sampled at the address phase, so a write in the previous
  // transfer's data phase (this same cycle) is not yet visible, nor is an event
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_hrdata <= '0;
    end else if (addr_ok && !i_hwrite) begin
      o_hrdata <= next_rdata;
    end
  end

  // mode is set through its own control word; the status copy is read-only
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      operating_mode <= EPS_MODE_RESET;
    end else if (wr_mode) begin
      operating_mode <= i_hwdata[1:0];
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      irq_mask <= EPS_MASK_RESET;
    end else if (wr_mask) begin
      irq_mask <= i_hwdata[EPS_TXB_BIT:1];
    end
  end

  // a new request clears the flag, completion sets it; completion wins
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      access_done <= 1'b0;
    end else begin
      access_done <= (access_done && !i_vacc_start) || i_vacc_done;
    end
  end

  assign fault_evt = (i_bus_master && !ext_fault_sync_n) ||
                     i_host_wr_parity_err || i_mem_rd_parity_err;
  assign fault_new = fault_evt && !bus_fault_flag;
  // a suspended process fetches nothing, so it cannot fail again
  assign rdu_set = i_rx_desc_host_owned && (rx_state == EPS_RUNNING);
  assign rfd_set = i_rx_frame_done || i_rx_wdog_expire;

  // sticky flags: set wins over a write-one clear in the same cycle
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      remote_start_msg_flag <= 1'b0;
      tx_babble_flag <= 1'b0;
      rx_babble_flag <= 1'b0;
      bus_fault_flag <= 1'b0;
      rx_desc_unavail_flag <= 1'b0;
      rx_frame_done_flag <= 1'b0;
    end else begin
      remote_start_msg_flag <= (remote_start_msg_flag &&
        !(wr_status && i_hwdata[EPS_BOOT_BIT])) || i_boot_msg_det;
      tx_babble_flag <= (tx_babble_flag &&
        !(wr_status && i_hwdata[EPS_TXB_BIT])) || i_tx_wdog_expire;
      rx_babble_flag <= (rx_babble_flag &&
        !(wr_status && i_hwdata[EPS_RXB_BIT])) || i_rx_wdog_expire;
      bus_fault_flag <= (bus_fault_flag &&
        !(wr_status && i_hwdata[EPS_FAULT_BIT])) || fault_evt;
      rx_desc_unavail_flag <= (rx_desc_unavail_flag &&
        !(wr_status && i_hwdata[EPS_RDU_BIT])) || rdu_set;
      rx_frame_done_flag <= (rx_frame_done_flag &&
        !(wr_status && i_hwdata[EPS_RFD_BIT])) || rfd_set;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_boot_ind <= 1'b0;
    end else begin
      o_boot_ind <= (o_boot_ind && !(wr_status && i_hwdata[EPS_BOOT_BIT])) ||
                    i_boot_msg_det;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tx_state <= EPS_STOPPED;
    end else if (fault_new || i_tx_wdog_expire || i_tx_stop) begin
      tx_state <= EPS_STOPPED;
    end else if (i_tx_start) begin
      tx_state <= EPS_RUNNING;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rx_state <= EPS_STOPPED;
    end else if (fault_new || i_rx_stop) begin
      rx_state <= EPS_STOPPED;
    end else begin
      unique case (rx_state)
        EPS_STOPPED: begin
          if (i_rx_start) begin
            rx_state <= EPS_RUNNING;
          end
        end
        EPS_RUNNING: begin
          if (rdu_set) begin
            rx_state <= EPS_SUSPENDED;
          end
        end
        EPS_SUSPENDED: begin
          if (i_rx_poll_demand || i_rx_frame_recognized) begin
            rx_state <= EPS_RUNNING;
          end
        end
      endcase
    end
  end

  assign o_tx_state = state_code(tx_state);
  assign o_rx_state = state_code(rx_state);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_tx_abort <= 1'b0;
      o_tx_desc_err <= 1'b0;
      o_rx_abort <= 1'b0;
      o_rx_desc_last_err <= 1'b0;
    end else begin
      o_tx_abort <= i_tx_wdog_expire || fault_new;
      o_tx_desc_err <= i_tx_wdog_expire;
      o_rx_abort <= i_rx_wdog_expire || fault_new;
      o_rx_desc_last_err <= i_rx_wdog_expire;
    end
  end

  // diagnostic mode keeps both paths quiet rather than guess a behaviour
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_med_tx_data <= '0;
      o_med_tx_valid <= 1'b0;
      o_loop_rx_data <= '0;
      o_loop_rx_valid <= 1'b0;
      o_addr_filter_en <= 1'b0;
    end else begin
      o_med_tx_data <= i_tx_data;
      o_loop_rx_data <= i_tx_data;
      o_med_tx_valid <= i_tx_valid && ((operating_mode == EPS_MODE_NORMAL) ||
                        (operating_mode == EPS_MODE_EXT_LOOP));
      o_loop_rx_valid <= i_tx_valid && ((operating_mode == EPS_MODE_INT_LOOP) ||
                         (operating_mode == EPS_MODE_EXT_LOOP));
      o_addr_filter_en <= (operating_mode != EPS_MODE_DIAG);
    end
  end

  assign o_irq = |({tx_babble_flag, rx_babble_flag, bus_fault_flag,
                    rx_desc_unavail_flag, rx_frame_done_flag, 1'b0} & irq_mask);

  chk_mode_ro: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr_status |=> operating_mode == $past(operating_mode))
    else $error("status write changed operating mode");
  chk_rsv_ones: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (addr_ok && !i_hwrite && i_haddr[EPS_ADDR_W-1:0] == EPS_OFF_STATUS)
    |=> o_hrdata[EPS_RSV_LSB+7:EPS_RSV_LSB] == EPS_RSV_VAL)
    else $error("reserved field did not read as ones");
  chk_int_loop: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_tx_valid && operating_mode == EPS_MODE_INT_LOOP && !wr_mode)
    |=> !o_med_tx_valid && o_loop_rx_valid && o_loop_rx_data == $past(i_tx_data))
    else $error("internal loopback path wrong");
  chk_ext_loop: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_tx_valid && operating_mode == EPS_MODE_EXT_LOOP && !wr_mode)
    |=> o_med_tx_valid && o_loop_rx_valid)
    else $error("external loopback path wrong");
  chk_done_set: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_vacc_done |=> access_done)
    else $error("access done not set");
  chk_tx_babble: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_tx_wdog_expire |=> tx_babble_flag && o_tx_abort && o_tx_desc_err &&
      o_tx_state == EPS_PS_STOPPED ##1 !o_tx_desc_err || $past(i_tx_wdog_expire))
    else $error("tx watchdog handling wrong");
  chk_rx_babble: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_rx_wdog_expire && rx_state == EPS_RUNNING && !fault_new && !i_rx_stop &&
     !i_rx_desc_host_owned)
    |=> rx_babble_flag && rx_frame_done_flag && o_rx_desc_last_err &&
        o_rx_state == EPS_PS_RUNNING)
    else $error("rx watchdog handling wrong");
  chk_fault_stop: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    fault_new |=> bus_fault_flag && o_tx_state == EPS_PS_STOPPED &&
      o_rx_state == EPS_PS_STOPPED && o_tx_abort && o_rx_abort)
    else $error("fault did not stop both processes");
  chk_pin_fault: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (!i_ext_fault_in_n && i_bus_master) [*4] |-> bus_fault_flag)
    else $error("fault pin not reported");

  chk_rdu_once: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (rx_state == EPS_SUSPENDED && wr_status && i_hwdata[EPS_RDU_BIT])
    |=> !rx_desc_unavail_flag)
    else $error("unavailable flag set again while suspended");

  chk_rx_resume: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (rx_state == EPS_SUSPENDED && i_rx_poll_demand && !fault_new && !i_rx_stop)
    |=> rx_state == EPS_RUNNING)
    else $error("reception did not resume");

  chk_set_wins: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_rx_frame_done && wr_status && i_hwdata[EPS_RFD_BIT]) |=> rx_frame_done_flag)
    else $error("clear beat a same-cycle event");

  chk_irq_follow: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (irq_mask == EPS_MASK_RESET) |-> (o_irq == summary_flag))
    else $error("interrupt does not follow summary");
endmodule : eps_port_status
`default_nettype wire

/* File: verification/eps_net_model.sv */
`timescale 1ns/1ps
`default_nettype none
// transmit-list source: sends four bytes per request, with a selectable gap so
// both prompt and slow delivery are exercised
module eps_net_model (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_go,
  input wire logic [3:0] i_gap,
  output logic [eps_pkg::EPS_STRM_W-1:0] o_data,
  output logic o_valid
);
  import eps_pkg::*;
  logic [2:0] left;
  logic [3:0] wait_cnt;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      left <= 3'h0;
      wait_cnt <= 4'h0;
      o_valid <= 1'b0;
      o_data <= 8'h00;
    end else if (i_go) begin
      left <= 3'h4;
      wait_cnt <= i_gap;
      o_valid <= 1'b0;
      o_data <= ~o_data;
    end else if (left != 3'h0 && wait_cnt == 4'h0) begin
      o_valid <= 1'b1;
      o_data <= 8'hA0 + {5'h00, left};
      left <= left - 3'h1;
      wait_cnt <= i_gap;
    end else begin
      // idle data line toggles so a stale byte is never mistaken for a fresh one
      o_valid <= 1'b0;
      o_data <= ~o_data;
      if (wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end
    end
  end
endmodule : eps_net_model
`default_nettype wire

/* File: verification/test_eps_port_status.sv */
`timescale 1ns/1ps
`default_nettype none
module test_eps_port_status;
  import eps_pkg::*;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
  logic bus_master = 1'b0, fault_n = 1'b1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0, tx_state, rx_state;
  logic [2:0] hsize = 3'h2;
  logic [14:0] ev = 15'h0;
  logic [3:0] gap = 4'h0;
  logic [7:0] sdata, med_data, loop_data;
  logic hready, hresp, irq, svalid, med_valid, loop_valid, filt, boot_ind;
  logic tx_abort, tx_derr, rx_abort, rx_derr;
  int num_errors = 0, cmp_count = 0, cyc = 0, n_med = 0, n_loop = 0;
  int s_med = 0, s_loop = 0;
  int ks[5] = '{2, 7, 10, 6, 5};
  logic [31:0] bits[5] = '{32'h80, 32'h08, 32'h04, 32'h10, 32'h10};

  eps_port_status eps_port_status_i (.i_clk_sys(clk), .i_rst(rst), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hready(hready), .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hreadyout(hready),
    .o_hresp(hresp), .o_irq(irq), .i_vacc_start(ev[0]), .i_vacc_done(ev[1]),
    .i_boot_msg_det(ev[2]), .i_tx_wdog_expire(ev[3]), .i_rx_wdog_expire(ev[4]),
    .i_bus_master(bus_master), .i_ext_fault_in_n(fault_n),
    .i_host_wr_parity_err(ev[5]), .i_mem_rd_parity_err(ev[6]),
    .i_rx_desc_host_owned(ev[7]), .i_rx_poll_demand(ev[8]),
    .i_rx_frame_recognized(ev[9]), .i_rx_frame_done(ev[10]), .i_tx_start(ev[11]),
    .i_tx_stop(ev[12]), .i_rx_start(ev[13]), .i_rx_stop(ev[14]), .i_tx_data(sdata),
    .i_tx_valid(svalid), .o_med_tx_data(med_data), .o_med_tx_valid(med_valid),
    .o_loop_rx_data(loop_data), .o_loop_rx_valid(loop_valid),
    .o_addr_filter_en(filt), .o_boot_ind(boot_ind), .o_tx_abort(tx_abort),
    .o_tx_desc_err(tx_derr), .o_rx_abort(rx_abort), .o_rx_desc_last_err(rx_derr),
    .o_tx_state(tx_state), .o_rx_state(rx_state));
  eps_net_model eps_net_model_i (.i_clk_sys(clk), .i_rst(rst), .i_go(go), .i_gap(gap),
    .o_data(sdata), .o_valid(svalid));

  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    n_med <= n_med + (med_valid === 1'b1 ? 1 : 0);
    n_loop <= n_loop + (loop_valid === 1'b1 ? 1 : 0);
    s_med <= s_med + (med_valid === 1'b1 ? int'(med_data) : 0);
    s_loop <= s_loop + (loop_valid === 1'b1 ? int'(loop_data) : 0);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t word got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic [1:0] got, input logic [1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t signal got %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  // one single transfer: address phase held until hready, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    #1;
  endtask : bus
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk_word(rd, exp);
    chk_bit(hresp, 2'b0);
  endtask : rchk
  task automatic pulse(input int k);
    @(posedge clk);
    ev <= 15'h1 << k;
    @(posedge clk);
    ev <= 15'h0;
    #1;
  endtask : pulse
  function automatic logic [31:0] st(input logic [31:0] b);
    return 32'h0000FF00 | b | {31'h0, b[6:1] != 6'h0};
  endfunction : st

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rchk(EPS_OFF_STATUS, 32'h0000FF00);
    rchk(EPS_OFF_MASK, 32'h0000007E);
    rchk(8'h40, 32'h0);
    bus(1'b1, EPS_OFF_STATUS, 32'hFFFFFFFF);
    rchk(EPS_OFF_STATUS, 32'h0000FF00);
    pulse(0);
    pulse(1);
    rchk(EPS_OFF_STATUS, 32'h0001FF00);
    pulse(0);
    rchk(EPS_OFF_STATUS, 32'h0000FF00);
    chk_bit(irq, 2'b0);
    pulse(13);
    pulse(11);
    chk_bit(rx_state, EPS_PS_RUNNING);
    for (int i = 0; i < 5; i++) begin
      pulse(ks[i]);
      if (i == 0) chk_bit(boot_ind, 2'b1);
      if (i == 1) chk_bit(rx_state, EPS_PS_SUSPENDED);
      rchk(EPS_OFF_STATUS, st(bits[i]));
      chk_bit(irq, {1'b0, bits[i][6:1] != 6'h0});
      bus(1'b1, EPS_OFF_STATUS, bits[i]);
      rchk(EPS_OFF_STATUS, 32'h0000FF00);
      chk_bit(irq, 2'b0);
      if (i == 1) begin
        pulse(7);
        rchk(EPS_OFF_STATUS, 32'h0000FF00);
        pulse(8);
        chk_bit(rx_state, EPS_PS_RUNNING);
        pulse(4);
        chk_bit({rx_abort, rx_derr}, 2'b11);
        chk_bit(rx_state, EPS_PS_RUNNING);
        rchk(EPS_OFF_STATUS, st(32'h24));
        bus(1'b1, EPS_OFF_STATUS, 32'h24);
        pulse(3);
        chk_bit({tx_abort, tx_derr}, 2'b11);
        chk_bit(tx_state, EPS_PS_STOPPED);
        rchk(EPS_OFF_STATUS, st(32'h40));
        bus(1'b1, EPS_OFF_STATUS, 32'h40);
        pulse(7);
        pulse(9);
        chk_bit(rx_state, EPS_PS_RUNNING);
        rchk(EPS_OFF_STATUS, st(32'h08));
        bus(1'b1, EPS_OFF_STATUS, 32'h08);
        pulse(11);
      end
      if (i == 3) begin
        chk_bit(tx_state, EPS_PS_STOPPED);
        chk_bit(rx_state, EPS_PS_STOPPED);
        pulse(13);
      end
    end
    pulse(11);
    pulse(13);
    chk_bit(tx_state, EPS_PS_RUNNING);
    chk_bit(rx_state, EPS_PS_RUNNING);
    pulse(12);
    pulse(14);
    chk_bit(tx_state, EPS_PS_STOPPED);
    chk_bit(rx_state, EPS_PS_STOPPED);
    chk_bit(boot_ind, 2'b0);
    bus(1'b1, EPS_OFF_MASK, 32'h0);
    pulse(10);
    chk_bit(irq, 2'b0);
    rchk(EPS_OFF_STATUS, st(32'h04));
    bus(1'b1, EPS_OFF_MASK, 32'h7E);
    chk_bit(irq, 2'b1);
    bus(1'b1, EPS_OFF_STATUS, 32'h04);
    // fault pin only counts while the device owns the bus
    @(posedge clk);
    fault_n <= 1'b0;
    repeat (6) @(posedge clk);
    rchk(EPS_OFF_STATUS, 32'h0000FF00);
    @(posedge clk);
    bus_master <= 1'b1;
    repeat (6) @(posedge clk);
    rchk(EPS_OFF_STATUS, st(32'h10));
    @(posedge clk);
    fault_n <= 1'b1;
    bus_master <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1'b1, EPS_OFF_STATUS, 32'h10);
    // after the fault: write each of the four operating modes to the mode register and check both paths
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, EPS_OFF_MODE, m);
      rchk(EPS_OFF_MODE, m);
      rchk(EPS_OFF_STATUS, 32'h0000FF00 | (m << EPS_OM_LSB));
      chk_bit(filt, {1'b0, m != 3});
      n_med = 0;
      n_loop = 0;
      s_med = 0;
      s_loop = 0;
      @(posedge clk);
      gap <= m[3:0];
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (30) @(posedge clk);
      chk_word(n_med, (m == 0 || m == 2) ? 4 : 0);
      chk_word(n_loop, (m == 1 || m == 2) ? 4 : 0);
      chk_word(s_med, (m == 0 || m == 2) ? 650 : 0);
      chk_word(s_loop, (m == 1 || m == 2) ? 650 : 0);
    end
    report_and_stop();
  end
endmodule : test_eps_port_status
`default_nettype wire
